/* pie_pkg.sv */
// constants, types and helpers for the protection-information engine
//
// Operation
// - unprotected namespace moves data and metadata with no tuple processing
// - write, action 0: pass data and full metadata unchanged, check tuple
// - mismatch completes command with guard, app tag or ref tag error status
// - write, action 1, metadata 8: take data only, append generated tuple
// - write, action 1, metadata above 8: overwrite only the tuple bytes
// - tuple sits at start or end of metadata per placement setting
// - read, action 0: pass data and full metadata unchanged, check tuple
// - read, action 1, metadata 8: check tuple then strip it
// - read, action 1, metadata above 8: check, pass tuple unmodified
// - each fused half is processed exactly as the same command alone
// - compare host half uses write handling, media half uses read handling
// - check-select bit 2 compares guard with computed CRC-16 over data
// - check-select bit 1 compares app tag, masked bits ignored
// - type 1 or 2 with bit 0 compares ref tag with seeded computed tag
// - computed ref tag increments per block for types 1, 2; constant type 3
// - type 1 initial ref tag must equal low four LBA bytes, else invalid
// - type 2 initial ref tag accepted as any value
// - type 3 with check-select bit 0 aborts with invalid protection status
// - type 1 or 2 block with app tag all ones skips all checks
// - type 3 skips checks only when app and ref tags are all ones
// - inserted tuple holds computed CRC, expected app tag, computed ref tag
// - guard covers metadata before a trailing tuple, none for a leading one
// - guard holds CRC-16 over block data; app tag otherwise opaque
package pie_pkg;

	localparam logic [15:0] PIE_CRC_POLY    = 16'h8bb7;
	localparam logic [15:0] PIE_CRC_INIT    = 16'h0000;
	localparam logic [15:0] PIE_TUPLE_BYTES = 16'h0008;
	localparam logic [15:0] PIE_APP_ESCAPE  = 16'hffff;
	localparam logic [31:0] PIE_REF_ESCAPE  = 32'hffffffff;
	localparam logic [7:0]  PIE_MD_TUPLE    = 8'h08;

	// tuple field positions within the 64-bit tuple word, msb first on the wire
	localparam int PIE_GUARD_LO = 48;
	localparam int PIE_APP_LO   = 32;
	localparam int PIE_REF_LO   = 0;

	// completion status codes
	localparam logic [2:0] PIE_ST_OK      = 3'h0;
	localparam logic [2:0] PIE_ST_GUARD   = 3'h1;
	localparam logic [2:0] PIE_ST_APP     = 3'h2;
	localparam logic [2:0] PIE_ST_REF     = 3'h3;
	localparam logic [2:0] PIE_ST_INV_PI  = 3'h4;

	typedef enum logic [1:0] {PIE_TYPE_NONE, PIE_TYPE_1, PIE_TYPE_2, PIE_TYPE_3} pie_type_t;
	typedef enum logic [1:0] {PIE_OP_WRITE, PIE_OP_READ, PIE_OP_CMP_HOST, PIE_OP_CMP_MEDIA} pie_op_t;

	// one byte of crc-16, msb first, no reflection
	function automatic logic [15:0] pie_crc_byte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			c = c[15] ? ((c << 1) ^ PIE_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

endpackage

/* pie_engine.sv */
// inline end-to-end protection tuple engine on a byte stream
`timescale 1ns/1ps
module pie_engine import pie_pkg::*; #(
	parameter int BLK_BYTES = 512
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire pie_type_t   ns_pi_type,
	input  wire logic        pi_placement_setting,
	input  wire logic [7:0]  metadata_size,
	input  wire logic        cmd_valid,
	input  wire pie_op_t     cmd_op,
	input  wire logic        pi_action_bit,
	input  wire logic [2:0]  pi_check_select,
	input  wire logic [15:0] expected_app_tag,
	input  wire logic [15:0] app_tag_mask,
	input  wire logic [31:0] initial_ref_tag,
	input  wire logic [31:0] start_lba_low,
	input  wire logic [15:0] block_count,
	output logic             cmd_ready,
	input  wire logic        in_valid,
	input  wire logic [7:0]  in_data,
	output logic             in_ready,
	output logic             out_valid,
	output logic [7:0]       out_data,
	input  wire logic        out_ready,
	output logic             done,
	output logic [2:0]       status
);

	localparam logic [15:0] BLK = 16'(BLK_BYTES);

	// block plus largest metadata must fit the 16-bit position counter
	if (BLK_BYTES < 1 || BLK_BYTES > 65535 - 255) begin : g_chk
		$error("pie_engine: BLK_BYTES out of range");
	end

	typedef enum logic [1:0] {PIE_S_IDLE, PIE_S_RUN, PIE_S_DRAIN} pie_state_t;

	pie_state_t  state, next_state;
	pie_op_t     op, next_op;
	pie_type_t   ptype, next_ptype;
	logic        act, next_act;
	logic        first, next_first;
	logic [7:0]  md, next_md;
	logic [2:0]  chk, next_chk;
	logic [15:0] exp_app, next_exp_app;
	logic [15:0] mask, next_mask;
	logic [31:0] ref_calc, next_ref_calc;
	logic [15:0] blocks_left, next_blocks_left;
	logic [15:0] pos, next_pos;
	logic [15:0] crc, next_crc;
	logic [63:0] tup, next_tup;
	logic [2:0]  err, next_err;
	logic [7:0]  buf0, next_buf0;
	logic [7:0]  buf1, next_buf1;
	logic [1:0]  cnt, next_cnt;
	logic        next_cmd_ready;
	logic        next_in_ready;
	logic        next_out_valid;
	logic        next_done;
	logic [2:0]  next_status;

	// per-command mode decode
	logic        prot, wdir, ins, strip, gen, chk_on, t12;
	logic [15:0] blk_len, tstart, tidx16;
	logic        in_tuple, need_in, emit, step, push, pop, last;
	logic [7:0]  byte_in, byte_out, gen_byte;
	logic [63:0] gen_tuple, done_tup;
	logic        esc, g_err, a_err, r_err;

	// mode decode and byte path
	always_comb begin
		prot = (ptype != PIE_TYPE_NONE);
		t12  = (ptype == PIE_TYPE_1) || (ptype == PIE_TYPE_2);
		wdir = (op == PIE_OP_WRITE) || (op == PIE_OP_CMP_HOST);
		gen    = prot && wdir && act;
		ins    = gen && (md == PIE_MD_TUPLE);
		strip  = prot && !wdir && act && (md == PIE_MD_TUPLE);
		// action 0 checks only; check on read
		chk_on = prot && !gen;
		blk_len = BLK + {8'h00, md};
		tstart  = first ? BLK : 16'(BLK + {8'h00, md} - PIE_TUPLE_BYTES);
		tidx16  = pos - tstart;
		in_tuple = prot && (pos >= tstart) && (pos < 16'(tstart + PIE_TUPLE_BYTES));
		need_in  = !(ins && pos >= BLK);
		emit     = !(strip && pos >= BLK);
		gen_tuple = {crc, exp_app, ref_calc};
		gen_byte  = 8'(gen_tuple >> (8'd56 - {2'b00, tidx16[2:0], 3'b000}));
		byte_in   = need_in ? in_data : 8'h00;
		byte_out  = (gen && in_tuple) ? gen_byte : byte_in;
		pop  = out_valid && out_ready;
		step = (state == PIE_S_RUN) && (need_in ? (in_valid && in_ready) : (cnt < 2'd2));
		push = step && emit;
		last = step && (pos == blk_len - 16'd1);
		done_tup = (step && in_tuple) ? {tup[55:0], byte_in} : tup;
	end

	// tuple checks at block end
	always_comb begin
		// type 1/2 escape; type 3 escape
		esc = (t12 && done_tup[PIE_APP_LO +: 16] == PIE_APP_ESCAPE) ||
		      (ptype == PIE_TYPE_3 && done_tup[PIE_APP_LO +: 16] == PIE_APP_ESCAPE &&
		       done_tup[PIE_REF_LO +: 32] == PIE_REF_ESCAPE);
		g_err = chk[2] && (done_tup[PIE_GUARD_LO +: 16] != crc);
		a_err = chk[1] && (((done_tup[PIE_APP_LO +: 16] ^ exp_app) & mask) != 16'h0000);
		// ref tag compare for types 1 and 2
		r_err = chk[0] && t12 && (done_tup[PIE_REF_LO +: 32] != ref_calc);
	end

	// command and stream sequencing
	always_comb begin
		next_state       = state;
		next_op          = op;
		next_ptype       = ptype;
		next_act         = act;
		next_first       = first;
		next_md          = md;
		next_chk         = chk;
		next_exp_app     = exp_app;
		next_mask        = mask;
		next_ref_calc    = ref_calc;
		next_blocks_left = blocks_left;
		next_pos         = pos;
		next_crc         = crc;
		next_tup         = tup;
		next_err         = err;
		next_done        = 1'b0;
		next_status      = status;
		unique case (state)
			PIE_S_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					// every command set up alone, fused or not
					next_op          = cmd_op;
					next_ptype       = ns_pi_type;
					next_act         = pi_action_bit;
					next_first       = pi_placement_setting;
					next_md          = metadata_size;
					next_chk         = pi_check_select;
					next_exp_app     = expected_app_tag;
					next_mask        = app_tag_mask;
					// type 2 seed taken as given
					next_ref_calc    = initial_ref_tag;
					next_blocks_left = block_count;
					next_pos         = 16'h0000;
					next_crc         = PIE_CRC_INIT;
					next_err         = PIE_ST_OK;
					// type 1 seed must match lba
					if (ns_pi_type == PIE_TYPE_1 && initial_ref_tag != start_lba_low) begin
						next_done   = 1'b1;
						next_status = PIE_ST_INV_PI;
					end else if (ns_pi_type == PIE_TYPE_3 && pi_check_select[0]) begin
						next_done   = 1'b1;
						next_status = PIE_ST_INV_PI;
					end else if (block_count == 16'h0000) begin
						next_done   = 1'b1;
						next_status = PIE_ST_OK;
					end else begin
						next_state = PIE_S_RUN;
					end
				end
			end
			PIE_S_RUN: begin
				if (step) begin
					next_pos = pos + 16'd1;
					// crc over data and metadata ahead of tuple
					if (pos < tstart) begin
						next_crc = pie_crc_byte(crc, byte_in);
					end
					if (in_tuple) begin
						next_tup = done_tup;
					end
					if (last) begin
						next_pos = 16'h0000;
						next_crc = PIE_CRC_INIT;
						if (chk_on && !esc && err == PIE_ST_OK) begin
							if (g_err) begin
								next_err = PIE_ST_GUARD;
							end else if (a_err) begin
								next_err = PIE_ST_APP;
							end else if (r_err) begin
								next_err = PIE_ST_REF;
							end
						end
						// ref tag steps for types 1 and 2 only
						if (t12) begin
							next_ref_calc = ref_calc + 32'd1;
						end
						next_blocks_left = blocks_left - 16'd1;
						if (blocks_left == 16'd1) begin
							next_state = PIE_S_DRAIN;
						end
					end
				end
			end
			PIE_S_DRAIN: begin
				// completion waits until the last byte has left the buffer
				if (cnt == 2'd0 || (cnt == 2'd1 && pop)) begin
					next_state  = PIE_S_IDLE;
					next_done   = 1'b1;
					next_status = err;
				end
			end
		endcase
	end

	// two-entry output buffer, a receiver stall back-pressures the input
	always_comb begin
		next_buf0 = buf0;
		next_buf1 = buf1;
		next_cnt  = cnt;
		if (push && !pop) begin
			if (cnt == 2'd0) begin
				next_buf0 = byte_out;
			end else begin
				next_buf1 = byte_out;
			end
			next_cnt = cnt + 2'd1;
		end else if (!push && pop) begin
			next_buf0 = buf1;
			next_cnt  = cnt - 2'd1;
		end else if (push && pop) begin
			if (cnt == 2'd1) begin
				next_buf0 = byte_out;
			end else begin
				next_buf0 = buf1;
				next_buf1 = byte_out;
			end
		end
	end

	// registered handshake outputs, ready only when a slot is free
	always_comb begin
		next_out_valid = (next_cnt != 2'd0);
		next_cmd_ready = (next_state == PIE_S_IDLE);
		next_in_ready  = (next_state == PIE_S_RUN) && (next_cnt < 2'd2) &&
		                 !(ins && next_pos >= BLK);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state       <= PIE_S_IDLE;
			op          <= PIE_OP_WRITE;
			ptype       <= PIE_TYPE_NONE;
			act         <= 1'b0;
			first       <= 1'b0;
			md          <= 8'h00;
			chk         <= 3'h0;
			exp_app     <= 16'h0000;
			mask        <= 16'h0000;
			ref_calc    <= 32'h00000000;
			blocks_left <= 16'h0000;
			pos         <= 16'h0000;
			crc         <= PIE_CRC_INIT;
			tup         <= 64'h0000000000000000;
			err         <= PIE_ST_OK;
			buf0        <= 8'h00;
			buf1        <= 8'h00;
			cnt         <= 2'd0;
			cmd_ready   <= 1'b0;
			in_ready    <= 1'b0;
			out_valid   <= 1'b0;
			done        <= 1'b0;
			status      <= PIE_ST_OK;
		end else begin
			state       <= next_state;
			op          <= next_op;
			ptype       <= next_ptype;
			act         <= next_act;
			first       <= next_first;
			md          <= next_md;
			chk         <= next_chk;
			exp_app     <= next_exp_app;
			mask        <= next_mask;
			ref_calc    <= next_ref_calc;
			blocks_left <= next_blocks_left;
			pos         <= next_pos;
			crc         <= next_crc;
			tup         <= next_tup;
			err         <= next_err;
			buf0        <= next_buf0;
			buf1        <= next_buf1;
			cnt         <= next_cnt;
			cmd_ready   <= next_cmd_ready;
			in_ready    <= next_in_ready;
			out_valid   <= next_out_valid;
			done        <= next_done;
			status      <= next_status;
		end
	end

	// head of the buffer is the output byte
	assign out_data = buf0;

endmodule

/* pie_engine_assertions.sv */
// port-level assertions for the protection tuple engine
`timescale 1ns/1ps
module pie_chk import pie_pkg::*; #(
	parameter int BLK_BYTES = 512
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire pie_type_t   ns_pi_type,
	input wire logic [2:0]  pi_check_select,
	input wire logic [31:0] initial_ref_tag,
	input wire logic [31:0] start_lba_low,
	input wire logic [15:0] block_count,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic        out_valid,
	input wire logic [7:0]  out_data,
	input wire logic        out_ready,
	input wire logic        done,
	input wire logic [2:0]  status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// completion and command handshake
	a_done_pulse: assert property (done |=> !done) else $error("done too long");
	a_done_ready: assert property (done |-> cmd_ready) else $error("busy at done");
	// a refused or empty command completes at once and stays ready, all others go busy
	a_take_busy: assert property (cmd_valid && cmd_ready |=> cmd_ready == done)
		else $error("not busy");
	// stalled output must not move, or a word is lost
	a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("output moved in stall");
	a_idle_empty: assert property (cmd_ready |-> !out_valid) else $error("output while idle");
	a_status_done: assert property ($changed(status) |-> done) else $error("status moved");
	a_t3_abort: assert property (cmd_valid && cmd_ready && ns_pi_type == PIE_TYPE_3
		&& pi_check_select[0] && block_count != 16'h0 |=> done && status == PIE_ST_INV_PI)
		else $error("type 3 ref check not refused");
	a_seed_check: assert property (cmd_valid && cmd_ready && ns_pi_type == PIE_TYPE_1
		&& initial_ref_tag != start_lba_low && block_count != 16'h0
		|=> done && status == PIE_ST_INV_PI) else $error("bad seed not refused");
endmodule

bind pie_engine pie_chk #(.BLK_BYTES(BLK_BYTES)) u_pie_chk (.clk(clk), .reset(reset),
	.ns_pi_type(ns_pi_type), .pi_check_select(pi_check_select),
	.initial_ref_tag(initial_ref_tag), .start_lba_low(start_lba_low),
	.block_count(block_count), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .done(done),
	.status(status));

/* pie_host_sink.sv */
// receiving buffer model that may stall the output stream
`timescale 1ns/1ps
module pie_host_sink (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic stall_en,
	output logic      out_ready
);
	// random ready in stall mode fills the two-entry buffer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= stall_en ? 1'($urandom % 3 == 0) : 1'b1;
		end
	end
endmodule

/* pie_engine_tb.sv */
// self-checking bench for the protection tuple engine
`timescale 1ns/1ps
module pie_engine_tb import pie_pkg::*;;
	pie_type_t   ty = PIE_TYPE_NONE;
	pie_op_t     op = PIE_OP_WRITE;
	logic        clk = 0, reset = 1, cmd_valid = 0, act = 0, pl = 0, in_valid = 0, stall = 0;
	logic        cmd_ready, in_ready, out_valid, out_ready, done;
	logic [2:0]  ck = 0, status;
	logic [7:0]  md = 0, in_data = 0, out_data;
	logic [15:0] eapp = 0, nblk = 0, mk = 0;
	logic [31:0] seed = 0, lba = 0;
	logic [7:0]  exp_q[$];
	logic [2:0]  st_q[$];
	int          n_mismatch = 0, total_checks = 0;

	pie_engine #(.BLK_BYTES(8)) u_pie_engine (.clk(clk), .reset(reset), .ns_pi_type(ty),
		.pi_placement_setting(pl), .metadata_size(md), .cmd_valid(cmd_valid), .cmd_op(op),
		.pi_action_bit(act), .pi_check_select(ck), .expected_app_tag(eapp),
		.app_tag_mask(mk), .initial_ref_tag(seed), .start_lba_low(lba),
		.block_count(nblk), .cmd_ready(cmd_ready), .in_valid(in_valid), .in_data(in_data),
		.in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
		.out_ready(out_ready), .done(done), .status(status));
	pie_host_sink u_pie_host_sink (.clk(clk), .reset(reset), .stall_en(stall),
		.out_ready(out_ready));

	// 40 mhz clock
	initial forever #12.5 clk = ~clk;

	task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// crc-16 one byte, msb first
	function automatic logic [15:0] crc_b(logic [15:0] c, logic [7:0] b);
		c ^= {b, 8'h00};
		repeat (8) c = c[15] ? (c << 1) ^ PIE_CRC_POLY : c << 1;
		return c;
	endfunction

	// metadata: tuple first or last
	function automatic void md_push(ref logic [7:0] dq[$], input logic [7:0] ex[$],
			input logic [63:0] t, input logic p);
		if (!p) foreach (ex[i]) dq.push_back(ex[i]);
		for (int k = 7; k >= 0; k--) dq.push_back(t[k*8+:8]);
		if (p) foreach (ex[i]) dq.push_back(ex[i]);
	endfunction

	// two blocks; bad: 1 guard, 2 app, 3 ref, 4 escape, 5 seed, 6 no blocks
	task automatic run(pie_op_t o, logic a, pie_type_t t, logic [2:0] c, int bad,
			logic [7:0] m, logic p);
		logic [7:0]  q[$], ex[$], x;
		logic [15:0] crc, e;
		logic [31:0] s;
		logic [63:0] tp, gt;
		bit          wr, rej;
		int          st, n;
		int          fpos[5] = '{64, 48, 40, 0, 48};
		wr = o == PIE_OP_WRITE || o == PIE_OP_CMP_HOST;
		s = $urandom;
		e = 16'($urandom);
		// random mask, bit 0 always ignored and bit 8 always compared
		mk <= 16'($urandom) & 16'hfefe | 16'h0100;
		op <= o;
		act <= a;
		ty <= t;
		ck <= c;
		md <= m;
		pl <= p;
		nblk <= bad == 6 ? 16'h0 : 16'h2;
		seed <= s;
		eapp <= e;
		lba <= bad == 5 ? ~s : s;
		stall <= ~stall;
		rej = t == PIE_TYPE_1 && bad == 5 || t == PIE_TYPE_3 && c[0] || bad == 6;
		st = rej && bad != 6 ? 4 : 0;
		for (int b = 0; b < 2 && !rej; b++) begin
			crc = 16'h0;
			ex = {};
			for (int i = 0; i < m; i++) begin
				x = 8'($urandom);
				if (i < 8) crc = crc_b(crc, x);
				if (i < 8) q.push_back(x);
				if (i < 8) exp_q.push_back(x);
				else ex.push_back(x);
			end
			if (!p) foreach (ex[i]) crc = crc_b(crc, ex[i]);
			gt = {crc, e, t == PIE_TYPE_3 ? s : s + b};
			tp = gt ^ 64'h1_0000_0000;
			if (b == 1) tp ^= 64'h1 << fpos[bad % 5];
			if (b == 1 && bad == 4) tp[47:32] = 16'hffff;
			// first error, guard before app before ref
			if (b == 1 && t != PIE_TYPE_NONE && !(wr && a) && !(bad == 4 && t != PIE_TYPE_3))
				st = c[2] && bad inside {1, 4} ? 1 : c[1] && bad == 2 ? 2 : c[0] && bad == 3 ? 3 : 0;
			if (!(wr && a && m == 8)) md_push(q, ex, tp, p);
			if (!(!wr && a && m == 8)) md_push(exp_q, ex, wr && a ? gt : tp, p);
		end
		st_q.push_back(st[2:0]);
		cmd_valid <= 1'b1;
		do @(posedge clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		foreach (q[i]) begin
			in_valid <= 1'b1;
			in_data <= q[i];
			do @(posedge clk); while (in_ready !== 1'b1);
		end
		in_valid <= 1'b0;
		in_data <= ~in_data;
		n = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		// a command that never completes is a failure
		if (n >= 4000) n_mismatch++;
	endtask

	// output watcher: oldest note against each result
	always @(posedge clk) begin
		if (reset === 1'b0 && out_valid === 1'b1 && out_ready === 1'b1)
			chk("out_data", out_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
		if (reset === 1'b0 && done === 1'b1)
			chk("status", 8'(status), st_q.size() ? 8'(st_q.pop_front()) : 8'hxx);
	end

	// main sequence
	initial begin
		void'($urandom(32'hd160cb27));
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		run(PIE_OP_READ, 0, PIE_TYPE_1, 7, 0, 8, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_1, 7, 1, 8, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_2, 7, 2, 16, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_1, 7, 3, 16, 1);
		run(PIE_OP_READ, 1, PIE_TYPE_1, 7, 0, 8, 0);
		run(PIE_OP_READ, 1, PIE_TYPE_2, 7, 0, 16, 1);
		run(PIE_OP_WRITE, 1, PIE_TYPE_1, 7, 1, 8, 0);
		run(PIE_OP_WRITE, 1, PIE_TYPE_3, 6, 0, 16, 0);
		run(PIE_OP_WRITE, 0, PIE_TYPE_2, 7, 3, 8, 0);
		run(PIE_OP_CMP_HOST, 0, PIE_TYPE_1, 3, 1, 8, 0);
		run(PIE_OP_CMP_MEDIA, 1, PIE_TYPE_1, 7, 0, 8, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_1, 7, 5, 8, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_2, 7, 5, 8, 0);
		run(PIE_OP_WRITE, 0, PIE_TYPE_2, 7, 6, 8, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_3, 7, 0, 8, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_1, 7, 4, 8, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_3, 6, 4, 8, 0);
		run(PIE_OP_READ, 0, PIE_TYPE_NONE, 7, 1, 8, 0);
		repeat (4) @(posedge clk);
		chk("bytes left", 8'(exp_q.size()), 8'h00);
		chk("status left", 8'(st_q.size()), 8'h00);
		final_report();
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
endmodule
